/* File: hw/amb_ctrl.sv */
// mode, burst sequencing and overrange control for two channel pairs
`timescale 1ns/1ps
`include "amb_defs.svh"
module amb_ctrl (
	// clock, reset, enable
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// pins from the board
	input wire logic boost_mode_pin_in,
	input wire logic burst_trigger_in,
	// register port of the serial control logic
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	// conversion results, channels A to D
	input wire logic [13:0] conv_a_in,
	input wire logic [13:0] conv_b_in,
	input wire logic [13:0] conv_c_in,
	input wire logic [13:0] conv_d_in,
	input wire logic [3:0] conv_overdrive_in,
	// output words, bit 0 is the lane zero content
	output logic [13:0] word_a_out,
	output logic [13:0] word_b_out,
	output logic [13:0] word_c_out,
	output logic [13:0] word_d_out,
	output logic [1:0] pair_clk_out,
	// flags and mode per pair, index 0 is pair AB
	output logic [1:0] high_res_flag_out,
	output logic [1:0] trigger_ready_flag_out,
	output amb_pkg::amb_mode_type ab_mode_out,
	output amb_pkg::amb_mode_type cd_mode_out
);
	// register storage
	logic auto_burst_reg;
	logic band45_reg;
	logic boost_pin_override_reg;
	logic normal_ovr_sel_reg;
	logic [1:0] burst_enable_reg;
	logic [3:0] high_count_exponent_reg;
	logic [1:0] low_ratio_exponent_reg;
	logic [7:0] early_overrange_threshold_reg;
	// pin synchronisers
	logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
	logic boost_s1_reg, boost_s2_reg;
	// sequencer state per pair
	amb_pkg::amb_seq_type seq_reg [2];
	logic [31:0] count_reg [2];
	logic [3:0] act_high_reg [2];
	logic [1:0] act_low_reg [2];
	// pipeline wiring
	logic [59:0] pipe_in, pipe_out;
	logic [3:0] fast_in, fast_out;
	logic [13:0] raw_d [4];
	logic [3:0] sat_d;
	logic [13:0] conv_raw [4];

	// all-ones mask below bit e, the last count of a set of 2^e
	function automatic logic [31:0] set_last(input logic [4:0] e);
		set_last = (32'h1 << e) - 32'h1;
	endfunction

	// magnitude of the top bits against the fast threshold
	function automatic logic over_thresh(input logic [13:0] s,
		input logic [7:0] thr);
		logic [13:0] mag;
		mag = s[13] ? ~s : s;
		over_thresh = ({mag[12:5], 1'b0} >= {thr, 1'b0});
	endfunction

	// 11-bit code with overdrive saturation
	function automatic logic [10:0] code11(input logic [13:0] s,
		input logic sat);
		code11 = sat ? (s[13] ? `AMB_SAT_NEG : `AMB_SAT_POS) :
			s[13:3];
	endfunction

	assign conv_raw[0] = conv_a_in;
	assign conv_raw[1] = conv_b_in;
	assign conv_raw[2] = conv_c_in;
	assign conv_raw[3] = conv_d_in;

	// register writes; reset values give plain 11-bit and fast overrange
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			auto_burst_reg <= 1'b0;
			band45_reg <= 1'b0;
			boost_pin_override_reg <= 1'b0;
			normal_ovr_sel_reg <= 1'b0;
			burst_enable_reg <= 2'h0;
			high_count_exponent_reg <= 4'h0;
			low_ratio_exponent_reg <= 2'h0;
			early_overrange_threshold_reg <= `AMB_RST_THRESH;
		end
		else if (clk_en_in && reg_wr_in)
		begin
			unique case (reg_addr_in)
				`AMB_ADDR_AUTO:
					auto_burst_reg <= reg_wdata_in[`AMB_BIT_AUTO];
				`AMB_ADDR_BAND:
					band45_reg <= reg_wdata_in[`AMB_BIT_BAND45];
				`AMB_ADDR_MISC:
				begin
					boost_pin_override_reg <=
						reg_wdata_in[`AMB_BIT_OVERRIDE];
					normal_ovr_sel_reg <=
						reg_wdata_in[`AMB_BIT_NORMAL_OVR];
				end
				`AMB_ADDR_BURST:
				begin
					burst_enable_reg[0] <=
						reg_wdata_in[`AMB_BIT_BURST_AB];
					burst_enable_reg[1] <=
						reg_wdata_in[`AMB_BIT_BURST_CD];
				end
				`AMB_ADDR_COUNT:
				begin
					high_count_exponent_reg <= reg_wdata_in[3:0];
					low_ratio_exponent_reg <= reg_wdata_in[5:4];
				end
				`AMB_ADDR_THRESH:
					early_overrange_threshold_reg <= reg_wdata_in;
				default:
				begin
				end
			endcase
		end
	end

	// register readback, state bits in the burst register's low bits
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 8'h00;
		else if (clk_en_in)
		begin
			unique case (reg_addr_in)
				`AMB_ADDR_AUTO:
					reg_rdata_out <= {7'h00, auto_burst_reg};
				`AMB_ADDR_BAND:
					reg_rdata_out <= {5'h00, band45_reg, 2'h0};
				`AMB_ADDR_MISC:
					reg_rdata_out <= {6'h00, normal_ovr_sel_reg,
						boost_pin_override_reg};
				`AMB_ADDR_BURST:
					reg_rdata_out <= {burst_enable_reg, 2'h0,
						seq_reg[1] == amb_pkg::SEQ_HIGH,
						seq_reg[0] == amb_pkg::SEQ_HIGH,
						boost_s2_reg, 1'b0};
				`AMB_ADDR_COUNT:
					reg_rdata_out <= {2'h0, low_ratio_exponent_reg,
						high_count_exponent_reg};
				`AMB_ADDR_THRESH:
					reg_rdata_out <= early_overrange_threshold_reg;
				default:
					reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// two-flop synchronisers for the pins, third flop for the edge
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			trig_s1_reg <= 1'b0;
			trig_s2_reg <= 1'b0;
			trig_s3_reg <= 1'b0;
			boost_s1_reg <= 1'b0;
			boost_s2_reg <= 1'b0;
		end
		else if (clk_en_in)
		begin
			trig_s1_reg <= burst_trigger_in;
			trig_s2_reg <= trig_s1_reg;
			trig_s3_reg <= trig_s2_reg;
			boost_s1_reg <= boost_mode_pin_in;
			boost_s2_reg <= boost_s1_reg;
		end
	end

	// burst sequencer, one independent copy per pair
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int p = 0; p < 2; p++)
			begin
				seq_reg[p] <= amb_pkg::SEQ_WAIT;
				count_reg[p] <= 32'h0;
				act_high_reg[p] <= 4'h0;
				act_low_reg[p] <= 2'h0;
			end
		end
		else if (clk_en_in)
		begin
			for (int p = 0; p < 2; p++)
			begin
				if (!burst_enable_reg[p])
				begin
					seq_reg[p] <= amb_pkg::SEQ_WAIT;
					count_reg[p] <= 32'h0;
					act_high_reg[p] <= high_count_exponent_reg;
					act_low_reg[p] <= low_ratio_exponent_reg;
				end
				else
				begin
					unique case (seq_reg[p])
						amb_pkg::SEQ_WAIT:
							if (trig_s2_reg && !trig_s3_reg)
							begin
								seq_reg[p] <= amb_pkg::SEQ_HIGH;
								count_reg[p] <= 32'h0;
							end
						amb_pkg::SEQ_HIGH:
							if (count_reg[p] == set_last(`AMB_HIGH_BASE
								+ {1'b0, act_high_reg[p]}))
							begin
								seq_reg[p] <= amb_pkg::SEQ_LOW;
								count_reg[p] <= 32'h0;
								act_high_reg[p] <=
									high_count_exponent_reg;
								act_low_reg[p] <=
									low_ratio_exponent_reg;
							end
							else
								count_reg[p] <= count_reg[p] + 32'h1;
						amb_pkg::SEQ_LOW:
							if (count_reg[p] == set_last(`AMB_LOW_BASE
								+ {1'b0, act_high_reg[p]}
								+ {3'h0, act_low_reg[p]}))
							begin
								count_reg[p] <= 32'h0;
								// auto repeats, manual waits; no edge seen
								seq_reg[p] <= auto_burst_reg ?
									amb_pkg::SEQ_HIGH :
									amb_pkg::SEQ_WAIT;
							end
							else
								count_reg[p] <= count_reg[p] + 32'h1;
						default:
							seq_reg[p] <= amb_pkg::SEQ_WAIT;
					endcase
				end
			end
		end
	end

	// data and normal overrange travel together, fast flag separately
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			pipe_in[c*15 +: 14] = conv_raw[c];
			pipe_in[c*15 + 14] = conv_overdrive_in[c];
			fast_in[c] = over_thresh(conv_raw[c],
				early_overrange_threshold_reg);
		end
	end

	amb_delay_line #(
		.WIDTH(60),
		.DEPTH(`AMB_DATA_LAT - 1)
	) u_data_pipe (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.data_in(pipe_in),
		.data_out(pipe_out)
	);

	amb_delay_line #(
		.WIDTH(4),
		.DEPTH(`AMB_FAST_LAT - 1)
	) u_fast_pipe (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.data_in(fast_in),
		.data_out(fast_out)
	);

	// unpack the delayed data
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			raw_d[c] = pipe_out[c*15 +: 14];
			sat_d[c] = pipe_out[c*15 + 14];
		end
	end

	// output words, flags and pair clocks, all from flops
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			word_a_out <= 14'h0000;
			word_b_out <= 14'h0000;
			word_c_out <= 14'h0000;
			word_d_out <= 14'h0000;
			high_res_flag_out <= 2'h0;
			trigger_ready_flag_out <= 2'h0;
			pair_clk_out <= 2'h0;
		end
		else if (clk_en_in)
		begin
			word_a_out <= form_word(0, seq_reg[0]);
			word_b_out <= form_word(1, seq_reg[0]);
			word_c_out <= form_word(2, seq_reg[1]);
			word_d_out <= form_word(3, seq_reg[1]);
			pair_clk_out <= ~pair_clk_out;
			for (int p = 0; p < 2; p++)
			begin
				high_res_flag_out[p] <=
					burst_enable_reg[p] &&
					seq_reg[p] == amb_pkg::SEQ_HIGH;
				trigger_ready_flag_out[p] <=
					burst_enable_reg[p] &&
					seq_reg[p] == amb_pkg::SEQ_WAIT;
			end
		end
	end

	// one channel word: full sample in high set, else code plus lane zero
	function automatic logic [13:0] form_word(input int c,
		input amb_pkg::amb_seq_type st);
		logic overrange_flag;
		overrange_flag = normal_ovr_sel_reg ? sat_d[c] : fast_out[c];
		if (burst_enable_reg[c/2] && st == amb_pkg::SEQ_HIGH)
			form_word = raw_d[c];
		else
			form_word = {code11(raw_d[c], sat_d[c]), 2'h0, overrange_flag};
	endfunction

	// mode per pair from pin, override, band and burst bits
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ab_mode_out <= amb_pkg::MODE_PLAIN;
			cd_mode_out <= amb_pkg::MODE_PLAIN;
		end
		else if (clk_en_in)
		begin
			ab_mode_out <= pair_mode(burst_enable_reg[0]);
			cd_mode_out <= pair_mode(burst_enable_reg[1]);
		end
	end

	function automatic amb_pkg::amb_mode_type pair_mode(input logic b);
		logic boost;
		boost = boost_s2_reg || boost_pin_override_reg;
		if (b)
			pair_mode = amb_pkg::MODE_BURST;
		else if (boost && band45_reg)
			pair_mode = amb_pkg::MODE_BOOST45;
		else if (boost)
			pair_mode = amb_pkg::MODE_BOOST90;
		else
			pair_mode = amb_pkg::MODE_PLAIN;
	endfunction
endmodule

/* File: hw/amb_defs.svh */
// constants of the converter mode, burst and overrange control
`ifndef AMB_DEFS_SVH
`define AMB_DEFS_SVH
`define AMB_ADDR_AUTO 8'h41
`define AMB_ADDR_BAND 8'h42
`define AMB_ADDR_MISC 8'h43
`define AMB_ADDR_BURST 8'h44
`define AMB_ADDR_COUNT 8'h45
`define AMB_ADDR_THRESH 8'hC3
`define AMB_BIT_AUTO 0
`define AMB_BIT_BAND45 2
`define AMB_BIT_OVERRIDE 0
`define AMB_BIT_NORMAL_OVR 1
`define AMB_BIT_BURST_AB 6
`define AMB_BIT_BURST_CD 7
`define AMB_RST_THRESH 8'hE0
`define AMB_HIGH_BASE 5'h0A
`define AMB_LOW_BASE 5'h0D
`define AMB_FAST_LAT 7
`define AMB_DATA_LAT 10
`define AMB_SAT_POS 11'h3FF
`define AMB_SAT_NEG 11'h400
`endif

/* File: hw/amb_pkg.sv */
// types of the converter mode, burst and overrange control
package amb_pkg;
	typedef enum logic [1:0] {
		MODE_PLAIN,
		MODE_BOOST90,
		MODE_BOOST45,
		MODE_BURST
	} amb_mode_type;
	typedef enum logic [1:0] {
		SEQ_WAIT,
		SEQ_HIGH,
		SEQ_LOW
	} amb_seq_type;
endpackage

/* File: hw/amb_delay_line.sv */
// fixed-depth register delay line with clock enable
`timescale 1ns/1ps
module amb_delay_line #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// data
	input wire logic [WIDTH-1:0] data_in,
	output logic [WIDTH-1:0] data_out
);
	logic [WIDTH-1:0] stage_reg [DEPTH];

	// shift one stage per enabled cycle
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < DEPTH; i++)
				stage_reg[i] <= '0;
		end
		else if (clk_en_in)
		begin
			stage_reg[0] <= data_in;
			for (int i = 1; i < DEPTH; i++)
				stage_reg[i] <= stage_reg[i-1];
		end
	end

	assign data_out = stage_reg[DEPTH-1];
endmodule

/* File: verification/amb_ctrl_checker.sv */
// assertions on the ports of the mode, burst and overrange control
`timescale 1ns/1ps
module amb_ctrl_checker (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	// channel data and flags
	input wire logic [13:0] conv_a_in,
	input wire logic [13:0] conv_b_in,
	input wire logic [13:0] conv_c_in,
	input wire logic [13:0] conv_d_in,
	input wire logic [3:0] conv_overdrive_in,
	input wire logic [13:0] word_a_out,
	input wire logic [13:0] word_b_out,
	input wire logic [13:0] word_c_out,
	input wire logic [13:0] word_d_out,
	input wire logic [1:0] pair_clk_out,
	input wire logic [1:0] high_res_flag_out,
	input wire logic [1:0] trigger_ready_flag_out,
	input wire amb_pkg::amb_mode_type ab_mode_out,
	input wire amb_pkg::amb_mode_type cd_mode_out
);
	logic [11:0] hc;
	logic nrm;
	logic [13:0] mag;
	logic fa;
	logic w44;
	// fast threshold held at its reset value in the bench
	// ones complement magnitude, as the threshold compare uses
	assign mag = conv_a_in[13] ? ~conv_a_in : conv_a_in;
	assign fa = mag[12:5] >= 8'hE0;
	assign w44 = reg_wr_in && reg_addr_in == 8'h44;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// high run length and overrange select shadow
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			hc <= 12'h000;
			nrm <= 1'b0;
		end
		else
		begin
			hc <= high_res_flag_out[0] ? hc + 12'h001 : 12'h000;
			if (reg_wr_in && reg_addr_in == 8'h43)
				nrm <= reg_wdata_in[1];
		end
	chk_burst_ab_on:
	assert property (w44 && reg_wdata_in[6] |->
		##2 ab_mode_out == amb_pkg::MODE_BURST) else $error("ab burst");
	chk_burst_cd_on:
	assert property (w44 && reg_wdata_in[7] |->
		##2 cd_mode_out == amb_pkg::MODE_BURST) else $error("cd burst");
	chk_burst_off:
	assert property (w44 && !reg_wdata_in[6] |-> ##2
		ab_mode_out != amb_pkg::MODE_BURST ##1 !high_res_flag_out[0])
		else $error("burst off");
	chk_high_res_flag_mode:
	assert property (high_res_flag_out[0] |->
		ab_mode_out == amb_pkg::MODE_BURST) else $error("high_res_flag mode");
	chk_ready_wait:
	assert property (trigger_ready_flag_out[0] |-> !high_res_flag_out[0])
		else $error("ready in high set");
	chk_high_len:
	assert property ($fell(high_res_flag_out[0]) |-> hc == 12'h400)
		else $error("high set length");
	chk_high_res_flag_data:
	assert property (high_res_flag_out[0] |->
		word_a_out == $past(conv_a_in, 10)) else $error("high_res_flag word");
	chk_plain_data:
	assert property (!high_res_flag_out[0] &&
		!$past(conv_overdrive_in[0], 10) |-> word_a_out[13:1] ==
		{$past(conv_a_in[13:3], 10), 2'b00}) else $error("low word");
	chk_fast_ovr:
	assert property ($past(rst_n_in, 7) && !nrm && !$past(nrm) &&
		!high_res_flag_out[0] |->
		word_a_out[0] == $past(fa, 7)) else $error("fast ovr");
	chk_pair_words:
	assert property ($past(rst_n_in, 10) && high_res_flag_out == 2'b00 &&
		$past(conv_overdrive_in[3:1], 10) == 3'h0 |->
		word_b_out[13:3] == $past(conv_b_in[13:3], 10) &&
		word_c_out[13:3] == $past(conv_c_in[13:3], 10) &&
		word_d_out[13:3] == $past(conv_d_in[13:3], 10))
		else $error("pair words");
	chk_pair_clk:
	assert property (1'b1 |=> pair_clk_out == ~$past(pair_clk_out))
		else $error("pair clock");
endmodule
bind amb_ctrl amb_ctrl_checker u_chk (
	.ref_clk_in(ref_clk_in),
	.rst_n_in(rst_n_in),
	.reg_wr_in(reg_wr_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.conv_a_in(conv_a_in),
	.conv_b_in(conv_b_in),
	.conv_c_in(conv_c_in),
	.conv_d_in(conv_d_in),
	.conv_overdrive_in(conv_overdrive_in),
	.word_a_out(word_a_out),
	.word_b_out(word_b_out),
	.word_c_out(word_c_out),
	.word_d_out(word_d_out),
	.pair_clk_out(pair_clk_out),
	.high_res_flag_out(high_res_flag_out),
	.trigger_ready_flag_out(trigger_ready_flag_out),
	.ab_mode_out(ab_mode_out),
	.cd_mode_out(cd_mode_out)
);

/* File: verification/amb_rx_model.sv */
// receiver model that measures the high and low run lengths of the captured high-res flag
`timescale 1ns/1ps
module amb_rx_model (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// flag of the captured pair
	input wire logic hres_in,
	// lengths of the last high and low runs
	output int hi_n_out,
	output int lo_n_out
);
	int run;
	logic last;
	// run lengths from the flag, never from a count
	always_ff @(posedge ref_clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			run <= 0;
			last <= 1'b0;
			hi_n_out <= 0;
			lo_n_out <= 0;
		end
		else
		begin
			run <= (hres_in != last) ? 1 : run + 1;
			last <= hres_in;
			if (hres_in && !last)
				lo_n_out <= run;
			if (!hres_in && last)
				hi_n_out <= run;
		end
endmodule

/* File: verification/adc_mode_burst_overrange_ctrl_tb_top.sv */
// self-checking bench for the mode, burst and overrange control
`timescale 1ns/1ps
module adc_mode_burst_overrange_ctrl_tb_top;
	logic ref_clk_in, rst_n_in, clk_en_in, boost_mode_pin_in;
	logic burst_trigger_in, reg_wr_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic [13:0] conv_a_in, conv_b_in, conv_c_in, conv_d_in;
	logic [13:0] word_a_out, word_b_out, word_c_out, word_d_out;
	logic [3:0] conv_overdrive_in;
	logic [1:0] pair_clk_out, high_res_flag_out, trigger_ready_flag_out;
	amb_pkg::amb_mode_type ab_mode_out, cd_mode_out;
	logic [31:0] rs;
	int n_fail, checks, hi_n, lo_n, k;
	amb_ctrl u_dut (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.boost_mode_pin_in(boost_mode_pin_in),
		.burst_trigger_in(burst_trigger_in),
		.reg_wr_in(reg_wr_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out),
		.conv_a_in(conv_a_in),
		.conv_b_in(conv_b_in),
		.conv_c_in(conv_c_in),
		.conv_d_in(conv_d_in),
		.conv_overdrive_in(conv_overdrive_in),
		.word_a_out(word_a_out),
		.word_b_out(word_b_out),
		.word_c_out(word_c_out),
		.word_d_out(word_d_out),
		.pair_clk_out(pair_clk_out),
		.high_res_flag_out(high_res_flag_out),
		.trigger_ready_flag_out(trigger_ready_flag_out),
		.ab_mode_out(ab_mode_out),
		.cd_mode_out(cd_mode_out)
	);
	amb_rx_model u_rx (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.hres_in(high_res_flag_out[0]), .hi_n_out(hi_n), .lo_n_out(lo_n));
	// xorshift generator
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// mode expected from pin, band bit and burst bit
	function automatic amb_pkg::amb_mode_type em(input logic p, b, u);
		if (u)
			return amb_pkg::MODE_BURST;
		if (!p)
			return amb_pkg::MODE_PLAIN;
		return b ? amb_pkg::MODE_BOOST45 : amb_pkg::MODE_BOOST90;
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge ref_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		reg_wr_in = 1'b0;
		repeat (3) @(negedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr_in = a;
		repeat (2) @(negedge ref_clk_in);
	endtask
	// trigger pulse, 80 ns high
	task automatic pulse;
		@(negedge ref_clk_in);
		burst_trigger_in = 1'b1;
		repeat (10) @(negedge ref_clk_in);
		burst_trigger_in = 1'b0;
	endtask
	// bounded wait on the high flag or the ready flag of pair AB
	task automatic waitv(input logic sel, v);
		for (k = 0; k < 20000; k++)
		begin
			if ((sel ? trigger_ready_flag_out[0] :
				high_res_flag_out[0]) === v)
				break;
			@(negedge ref_clk_in);
		end
		chk("wait flag", k < 20000, 1'b1);
		// let the receiver model register the edge just seen
		@(negedge ref_clk_in);
	endtask
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	// random conversion results once out of reset
	always @(negedge ref_clk_in)
		if (rst_n_in)
		begin
			rs = xs(rs);
			conv_a_in = rs[13:0] == 14'h2000 ? 14'h0000 : rs[13:0];
			conv_b_in = rs[27:14];
			conv_c_in = ~rs[13:0];
			conv_d_in = rs[31:18];
		end
	// watchdog
	initial
	begin
		#600000;
		n_fail++;
		wrap_up;
	end
	initial
	begin
		rs = 32'h0001359A;
		n_fail = 0;
		checks = 0;
		rst_n_in = 1'b0;
		clk_en_in = 1'b1;
		boost_mode_pin_in = 1'b0;
		burst_trigger_in = 1'b0;
		reg_wr_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		conv_a_in = 14'h0000;
		conv_b_in = 14'h0000;
		conv_c_in = 14'h0000;
		conv_d_in = 14'h0000;
		conv_overdrive_in = 4'h0;
		repeat (5) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		chk("ab mode", ab_mode_out, em(0, 0, 0));
		chk("cd mode", cd_mode_out, em(0, 0, 0));
		rd(8'hC3);
		chk("thresh", reg_rdata_out, 8'hE0);
		rd(8'h50);
		chk("unmapped", reg_rdata_out, 8'h00);
		$display("test reset done");
		boost_mode_pin_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		chk("ab boost", ab_mode_out, em(1, 0, 0));
		wr(8'h42, 8'h04);
		chk("ab band", ab_mode_out, em(1, 1, 0));
		chk("cd band", cd_mode_out, em(1, 1, 0));
		wr(8'h42, 8'h00);
		$display("test boost done");
		wr(8'h44, 8'h40);
		chk("ab burst", ab_mode_out, em(1, 0, 1));
		chk("cd boost", cd_mode_out, em(1, 0, 0));
		chk("ready", trigger_ready_flag_out[0], 1'b1);
		repeat (200) @(negedge ref_clk_in);
		chk("no trig", high_res_flag_out[0], 1'b0);
		pulse;
		waitv(0, 1);
		waitv(0, 0);
		chk("high n", hi_n, 1024);
		chk("busy", trigger_ready_flag_out[0], 1'b0);
		pulse;
		waitv(1, 1);
		repeat (50) @(negedge ref_clk_in);
		chk("ignored", high_res_flag_out[0], 1'b0);
		$display("test manual done");
		wr(8'h41, 8'h01);
		rd(8'h41);
		chk("auto rd", reg_rdata_out, 8'h01);
		pulse;
		waitv(0, 1);
		waitv(0, 0);
		pulse;
		waitv(0, 1);
		chk("low n", lo_n, 8192);
		chk("high n", hi_n, 1024);
		waitv(0, 0);
		waitv(0, 1);
		chk("auto low", lo_n, 8192);
		waitv(0, 0);
		wr(8'h44, 8'hC0);
		chk("cd burst", cd_mode_out, em(1, 0, 1));
		chk("cd ready", trigger_ready_flag_out[1], 1'b1);
		wr(8'h44, 8'h00);
		chk("ab off", ab_mode_out, em(1, 0, 0));
		$display("test auto done");
		boost_mode_pin_in = 1'b0;
		wr(8'h43, 8'h02);
		@(negedge ref_clk_in);
		conv_overdrive_in = 4'h1;
		@(negedge ref_clk_in);
		conv_overdrive_in = 4'h0;
		repeat (8) @(negedge ref_clk_in);
		chk("ovr early", word_a_out[0], 1'b0);
		@(negedge ref_clk_in);
		chk("ovr", word_a_out[0], 1'b1);
		$display("test overrange done");
		wrap_up;
	end
endmodule
